// ### dv/twi_master_model.sv
`default_nettype none

// Behavioural two-wire master; the clock stands high outside frames
module twi_master_model (
	// Bus lines
	output var logic scl,    // Bus clock, made here only
	output var logic sda_oe, // High while pulling data low
	input  wire logic sda    // Resolved data line
);
	timeunit 1ns;
	timeprecision 1ns;

	localparam int QTR = 40; // Quarter of the 160 ns bit time

	// Idle bus: clock high, data released to the pull-up
	initial begin
		scl    = 1'b1;
		sda_oe = 1'b0;
	end

	// Master bit, changed mid low phase only
	task automatic put_bit(input logic b);
		#QTR sda_oe = ~b;
		#QTR scl = 1'b1;
		#(2*QTR) scl = 1'b0;
	endtask

	// Slave bit; unknown if it moves while clock high
	task automatic get_bit(output logic b);
		logic s0;
		#QTR sda_oe = 1'b0;
		#QTR scl = 1'b1;
		#1 s0 = sda;
		#(2*QTR-2) b = (sda === s0) ? s0 : 1'bx;
		#1 scl = 1'b0;
	endtask

	// Start or repeated start: data falls while clock high
	task automatic start();
		#QTR sda_oe = 1'b0;
		#QTR scl = 1'b1;
		#QTR sda_oe = 1'b1;
		#QTR scl = 1'b0;
	endtask

	// Stop: data rises while clock high
	task automatic stop();
		#QTR sda_oe = 1'b1;
		#QTR scl = 1'b1;
		#QTR sda_oe = 1'b0;
		#QTR;
	endtask

	// Byte out MSB first, then the ninth clock for the answer
	task automatic send_byte(input logic [7:0] d, output logic ack_n);
		for (int i = 7; i >= 0; i--) put_bit(d[i]);
		get_bit(ack_n);
	endtask

	// Byte in; low acknowledge held through clock high, withheld on the last
	task automatic recv_byte(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) get_bit(d[i]);
		put_bit(last);
	endtask
endmodule // twi_master_model

`default_nettype wire

// ### dv/two_wire_slave_register_port_bench.sv
`default_nettype none

module two_wire_slave_register_port_bench;
	timeunit 1ns;
	timeprecision 1ns;

	// Core side
	logic       core_clk;      // 20 MHz core clock
	logic       rst_n;         // Active-low reset
	logic       ce;            // Run enable
	// Bus
	logic       scl;           // From the master model
	logic       m_oe;          // Master pulls data low
	logic       sda;           // Wired-AND with pull-up
	logic       sda_out;       // Slave drive level
	logic       sda_oe;        // Slave pulls data low
	// Register space
	logic       wr_en;         // Write strobe
	logic [7:0] wr_addr;       // Write location
	logic [7:0] wr_data;       // Write byte
	logic       rd_en;         // Fetch strobe
	logic [7:0] rd_addr;       // Fetch location
	logic [7:0] rd_data;       // Fetched byte
	logic [7:0] mem [256];     // Register space model
	logic [7:0] exp_mem [256]; // What the bench expects there
	int         seed;          // Fixed random seed
	int         error_cnt;     // Mismatches
	int         n_checks;      // Comparisons

	// Open-drain resolution; released line reads high
	assign sda     = (sda_oe ? sda_out : 1'b1) & ~m_oe;
	// Fetch is combinational and only valid under the strobe
	assign rd_data = rd_en ? mem[rd_addr] : 8'h00;

	// Core clock, 50 ns period
	initial core_clk = 1'b0;
	always #25 core_clk = ~core_clk;

	// Register space takes strobed writes
	always @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	twi_slave_port u_dut (
		.core_clk(core_clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.scl     (scl),
		.sda_in  (sda),
		.sda_out (sda_out),
		.sda_oe  (sda_oe),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.rd_en   (rd_en),
		.rd_addr (rd_addr),
		.rd_data (rd_data)
	);

	twi_master_model u_master (
		.scl   (scl),
		.sda_oe(m_oe),
		.sda   (sda)
	);

	// Single comparison point
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Pointer then n bytes; keep leaves the bus held for a repeated start
	task automatic bus_write(input logic [7:0] ptr, input int n, input logic keep);
		logic       a;
		logic [7:0] d;
		logic [7:0] ad;
		u_master.start();
		u_master.send_byte({twi_port_pkg::DEV_ADDR, 1'b0}, a);
		check({7'h00, a}, 8'h00, "write address ack");
		u_master.send_byte(ptr, a);
		check({7'h00, a}, 8'h00, "pointer ack");
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			exp_mem[8'(ptr + i)] = d;
			u_master.send_byte(d, a);
			check({7'h00, a}, 8'h00, "data ack");
		end
		if (!keep) begin
			u_master.stop();
		end
		// Bounded wait for the crossing, then compare stored bytes
		for (int i = 0; i < n; i++) begin
			ad = 8'(ptr + i);
			for (int k = 0; k < 20 && mem[ad] !== exp_mem[ad]; k++) @(posedge core_clk);
			check(mem[ad], exp_mem[ad], "stored byte");
		end
	endtask

	// n bytes from the pointer; the last one gets a not-acknowledge
	task automatic bus_read(input logic [7:0] ptr, input int n);
		logic       a;
		logic [7:0] d;
		u_master.start();
		u_master.send_byte({twi_port_pkg::DEV_ADDR, 1'b1}, a);
		check({7'h00, a}, 8'h00, "read address ack");
		for (int i = 0; i < n; i++) begin
			u_master.recv_byte(i == n - 1, d);
			check(d, exp_mem[8'(ptr + i)], "read byte");
		end
		// Let the falling-edge update land first
		#5;
		check({7'h00, sda_oe}, 8'h00, "released after not-acknowledge");
		u_master.stop();
	endtask

	// Main sequence
	initial begin
		logic       a;
		logic [6:0] fa;
		logic [7:0] p;
		int         n;
		seed      = 89;
		error_cnt = 0;
		n_checks  = 0;
		rst_n     = 1'b0;
		ce        = 1'b0;
		for (int i = 0; i < 256; i++) begin
			mem[i]     = 8'($random(seed));
			exp_mem[i] = mem[i];
		end
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		ce    <= 1'b1;
		@(posedge core_clk);
		// Two idle pulses; the first finds the clock high, so the enable lands at the start's rising clock
		u_master.put_bit(1'b1);
		u_master.put_bit(1'b1);
		// Foreign address in both directions must be ignored
		for (int dir = 0; dir < 2; dir++) begin
			fa = 7'($random(seed));
			if (fa === twi_port_pkg::DEV_ADDR) begin
				fa = fa ^ 7'h01;
			end
			u_master.start();
			u_master.send_byte({fa, 1'(dir)}, a);
			check({7'h00, a}, 8'h01, "foreign address");
			u_master.send_byte(8'h10, a);
			check({7'h00, a}, 8'h01, "ignored until start");
			u_master.stop();
		end
		$display("test foreign done");
		// Corners: lowest and highest locations, then a continued read
		bus_write(8'h00, 1, 1'b0);
		bus_write(8'hfe, 2, 1'b0);
		bus_write(8'hfe, 0, 1'b1);
		bus_read(8'hfe, 2);
		bus_write(8'h10, 0, 1'b1);
		bus_read(8'h10, 1);
		bus_read(8'h11, 3);
		$display("test corners done");
		// Random bursts written, then read back after a repeated start
		for (int r = 0; r < 8; r++) begin
			p = 8'($random(seed)) & 8'hf7;
			n = 1 + ($random(seed) & 7);
			bus_write(p, n, 1'b0);
			bus_write(p, 0, 1'b1);
			bus_read(p, n);
		end
		$display("test random done");
		// Frozen port: address goes unanswered, then a clean stop and transfer
		@(posedge core_clk);
		ce <= 1'b0;
		u_master.start();
		u_master.send_byte({twi_port_pkg::DEV_ADDR, 1'b0}, a);
		check({7'h00, a}, 8'h01, "frozen port");
		u_master.stop();
		@(posedge core_clk);
		ce <= 1'b1;
		// Three pulses: the first finds the clock already high
		repeat (3) u_master.put_bit(1'b1);
		bus_write(8'h20, 2, 1'b0);
		bus_write(8'h20, 0, 1'b1);
		bus_read(8'h20, 2);
		$display("test freeze done");
		report_and_stop();
	end
endmodule // two_wire_slave_register_port_bench

`default_nettype wire

// ### hdl/core_bridge.sv
`default_nettype none

module core_bridge (
	// Core clock and reset
	input  wire logic       core_clk, // Core clock
	input  wire logic       rst_n,    // Async reset
	input  wire logic       ce,       // Low freezes all state
	// Crossing to the link side
	xfer_if.core            lx,       // Requests in, fetched bytes out
	// Register space access
	output logic            wr_en,    // One-cycle write strobe
	output logic [7:0]      wr_addr,  // Write location
	output logic [7:0]      wr_data,  // Write byte
	output logic            rd_en,    // One-cycle fetch strobe
	output logic [7:0]      rd_addr,  // Fetch location
	input  wire logic [7:0] rd_data   // Fetched byte, valid with rd_en
);
	logic req_m;    // First stage, read only by req_s
	logic req_s;    // Synchronised request toggle
	logic req_seen; // Last toggle served
	logic new_req;  // One request waiting

	assign new_req = req_s ^ req_seen;

	// Request toggle synchroniser
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_m <= 1'b0;
			req_s <= 1'b0;
		end else if (ce) begin
			req_m <= lx.req_tog;
			req_s <= req_m;
		end
	end

	// Strobes; link holds the words stable a full byte time
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_seen <= 1'b0;
			wr_en    <= 1'b0;
			rd_en    <= 1'b0;
			wr_addr  <= twi_port_pkg::BYTE_RST;
			wr_data  <= twi_port_pkg::BYTE_RST;
			rd_addr  <= twi_port_pkg::BYTE_RST;
		end else if (ce) begin
			if (new_req) begin
				req_seen <= req_s;
				wr_en    <= lx.req_we;
				wr_addr  <= lx.req_waddr;
				wr_data  <= lx.req_wdata;
				rd_en    <= 1'b1;
				rd_addr  <= lx.req_faddr;
			end else begin
				wr_en <= 1'b0;
				rd_en <= 1'b0;
			end
		end
	end

	// Fetched byte goes back with a toggle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lx.rsp_tog  <= 1'b0;
			lx.rsp_data <= twi_port_pkg::BYTE_RST;
		end else if (ce && rd_en) begin
			lx.rsp_data <= rd_data;
			lx.rsp_tog  <= ~lx.rsp_tog;
		end
	end

	a_write_strobe: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_en && ce |=> !wr_en)
		else $error("write strobe longer than one cycle");

	a_fetch_reply: assert property (@(posedge core_clk) disable iff (!rst_n)
		rd_en && ce |=> lx.rsp_data == $past(rd_data) && lx.rsp_tog != $past(lx.rsp_tog))
		else $error("fetched byte not returned");
endmodule // core_bridge

`default_nettype wire

// ### hdl/twi_port_pkg.sv
// Summary of operation
// - Receiver acknowledges every byte once addressed.
// - Acknowledge holds data low through clock high.
// - After master not-acknowledge, release the data line.
// - Write: address byte, data bytes, each acknowledged.
// - Transfer ends by stop or repeated start.
// - First byte after start: address plus direction.
// - First written data byte loads the pointer.
// - Further written bytes stored, pointer then advances.
// - Recognise start and stop as transfer bounds.
// - Acknowledge matching read address before sending data.
// - Read shifts out bytes from the pointer onward.
// - Pointer advances after every byte read.
// - Keep sending until a not-acknowledge arrives.
// - Start is data falling while clock high.
// - Stop is data rising while clock high.
// - Data changes only while the clock is low.
// - Eight data bits then one acknowledge bit.
`default_nettype none

package twi_port_pkg;
	localparam logic [6:0] DEV_ADDR  = 7'h6b; // Bus address of this port
	localparam logic [3:0] FIRST_BIT = 4'h1;  // Count after the first bit
	localparam logic [3:0] LAST_BIT  = 4'h7;  // Count before the eighth bit
	localparam logic [3:0] ACK_SLOT  = 4'h8;  // Count during the ninth bit
	localparam logic [3:0] CNT_RST   = 4'h0;  // Bit counter reset value
	localparam logic [7:0] PTR_RST   = 8'h00; // Pointer reset value
	localparam logic [7:0] PTR_STEP  = 8'h01; // Pointer advance per byte
	localparam logic [7:0] BYTE_RST  = 8'h00; // Data register reset value

	// Link side sequencer states
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000, // Bus free or after stop
		S_ADDR  = 3'b001, // Taking the address byte
		S_WPTR  = 3'b010, // Taking the pointer byte
		S_WDATA = 3'b011, // Taking data bytes
		S_RD    = 3'b100, // Sending data bytes
		S_IGN   = 3'b101  // Not ours or read ended, wait for start or stop
	} link_state_t;
endpackage

`default_nettype wire

// ### hdl/twi_slave_port.sv
`default_nettype none

module twi_slave_port (
	// Core clock, reset and freeze
	input  wire logic       core_clk, // Core clock
	input  wire logic       rst_n,    // Async reset
	input  wire logic       ce,       // Low freezes all but the bus toggles and the freeze and reply syncs
	// Two-wire bus
	input  wire logic       scl,      // Bus clock, from master only
	input  wire logic       sda_in,   // Data line level
	output logic            sda_out,  // Drive level, always low
	output logic            sda_oe,   // High while pulling data low
	// Register space access
	output logic            wr_en,    // One-cycle write strobe
	output logic [7:0]      wr_addr,  // Write location
	output logic [7:0]      wr_data,  // Write byte
	output logic            rd_en,    // One-cycle fetch strobe
	output logic [7:0]      rd_addr,  // Fetch location
	input  wire logic [7:0] rd_data   // Fetched byte, valid with rd_en
);
	// Crossing between the two clocks
	xfer_if lx ();

	// Bus condition toggles, clocked by the data line
	logic start_tog;  // Flips on each start
	logic stop_tog;   // Flips on each stop
	logic start_seen; // Copy in bus clock domain
	logic stop_seen;  // Copy in bus clock domain
	logic start_evt;  // Start since last rising clock
	logic stop_evt;   // Stop since last rising clock

	// Freeze and reply synchronisers
	logic ce_m;       // First stage, read only by ce_s
	logic ce_s;       // Freeze level in bus domain
	logic rsp_m;      // First stage, read only by rsp_s
	logic rsp_s;      // Synchronised reply toggle
	logic rsp_seen;   // Last reply taken

	// Sequencer
	twi_port_pkg::link_state_t st; // Transfer phase
	logic [3:0] cnt;      // Bits taken in this byte
	logic [7:0] shreg;    // Incoming bits
	logic [7:0] rx_byte;  // Byte as of this edge
	logic       ack;      // We answer the next ninth bit
	logic [7:0] ptr;      // Register pointer
	logic [7:0] pref;     // Byte at the pointer, fetched ahead
	logic [7:0] tx;       // Outgoing bits, MSB first

	// Decodes
	logic go;        // Ordinary bit edge, no bus condition
	logic active;    // In a phase that counts bits
	logic byte_done; // Eighth bit taken at this edge
	logic ack_slot;  // Ninth bit at this edge
	logic addr_hit;  // Address byte names this port
	logic load_tx;   // Next read byte starts

	// Start: data falls while clock high
	always_ff @(negedge sda_in or negedge rst_n) begin
		if (!rst_n) begin
			start_tog <= 1'b0;
		end else if (scl) begin
			start_tog <= ~start_tog;
		end
	end

	// Stop: data rises while clock high
	always_ff @(posedge sda_in or negedge rst_n) begin
		if (!rst_n) begin
			stop_tog <= 1'b0;
		end else if (scl) begin
			stop_tog <= ~stop_tog;
		end
	end

	// Toggles settle half a clock before the next rising edge,
	// so they are compared directly; a two-stage sync would
	// lose the first address bit.
	assign start_evt = start_tog ^ start_seen;
	assign stop_evt  = stop_tog ^ stop_seen;

	// A later start wins over an earlier stop
	assign go       = ce_s && !start_evt && !stop_evt;
	assign active   = (st == twi_port_pkg::S_ADDR) || (st == twi_port_pkg::S_WPTR) ||
		(st == twi_port_pkg::S_WDATA) || (st == twi_port_pkg::S_RD);
	assign byte_done = go && active && (cnt == twi_port_pkg::LAST_BIT);
	assign ack_slot  = go && active && (cnt == twi_port_pkg::ACK_SLOT);
	assign rx_byte   = {shreg[6:0], sda_in};
	assign addr_hit  = (rx_byte[7:1] == twi_port_pkg::DEV_ADDR);

	// Our own ack slot, or master ack sampled low
	assign load_tx = ack_slot && (st == twi_port_pkg::S_RD) && (ack || !sda_in);

	// Freeze level into the bus domain
	always_ff @(posedge scl or negedge rst_n) begin
		if (!rst_n) begin
			ce_m <= 1'b0;
			ce_s <= 1'b0;
		end else begin
			ce_m <= ce;
			ce_s <= ce_m;
		end
	end

	// Bus conditions taken at the next rising clock
	always_ff @(posedge scl or negedge rst_n) begin
		if (!rst_n) begin
			start_seen <= 1'b0;
			stop_seen  <= 1'b0;
		end else if (ce_s) begin
			start_seen <= start_tog;
			stop_seen  <= stop_tog;
		end
	end

	// Phase and bit count; the master makes every edge
	always_ff @(posedge scl or negedge rst_n) begin
		if (!rst_n) begin
			st  <= twi_port_pkg::S_IDLE;
			cnt <= twi_port_pkg::CNT_RST;
		end else if (ce_s) begin
			if (start_evt) begin
				// Start or repeated start opens an address byte
				st  <= twi_port_pkg::S_ADDR;
				cnt <= twi_port_pkg::FIRST_BIT;
			end else if (stop_evt) begin
				// Stop closes the transfer
				st  <= twi_port_pkg::S_IDLE;
				cnt <= twi_port_pkg::CNT_RST;
			end else if (active) begin
				// Nine clocks per byte
				cnt <= (cnt == twi_port_pkg::ACK_SLOT) ? twi_port_pkg::CNT_RST : cnt + 4'h1;
				if (byte_done) begin
					case (st)
						twi_port_pkg::S_ADDR: begin
							if (!addr_hit) begin
								st <= twi_port_pkg::S_IGN;
							end else if (rx_byte[0]) begin
								st <= twi_port_pkg::S_RD;
							end else begin
								st <= twi_port_pkg::S_WPTR;
							end
						end
						twi_port_pkg::S_WPTR: begin
							st <= twi_port_pkg::S_WDATA;
						end
						default: begin
							st <= st;
						end
					endcase
				end else if (ack_slot && st == twi_port_pkg::S_RD && !ack && sda_in) begin
					// Not-acknowledge ends the read; wait for stop or start
					st <= twi_port_pkg::S_IGN;
				end
			end
		end
	end

	// Incoming bits, sampled on the rising clock
	always_ff @(posedge scl or negedge rst_n) begin
		if (!rst_n) begin
			shreg <= twi_port_pkg::BYTE_RST;
		end else if (ce_s) begin
			if (start_evt) begin
				shreg <= {7'h00, sda_in};
			end else if (go && active) begin
				shreg <= rx_byte;
			end
		end
	end

	// Whether we answer the coming ninth bit
	always_ff @(posedge scl or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'b0;
		end else if (ce_s) begin
			if (start_evt || stop_evt) begin
				ack <= 1'b0;
			end else if (byte_done) begin
				if (st == twi_port_pkg::S_ADDR) begin
					ack <= addr_hit;
				end else begin
					// Any byte taken from the master is answered
					ack <= (st == twi_port_pkg::S_WPTR) || (st == twi_port_pkg::S_WDATA);
				end
			end else if (ack_slot) begin
				ack <= 1'b0;
			end
		end
	end

	// Pointer and requests to the core side. Each request is
	// held a whole byte time, which covers the core round trip
	// while the core clock is at least a few times faster.
	always_ff @(posedge scl or negedge rst_n) begin
		if (!rst_n) begin
			ptr          <= twi_port_pkg::PTR_RST;
			lx.req_tog   <= 1'b0;
			lx.req_we    <= 1'b0;
			lx.req_waddr <= twi_port_pkg::BYTE_RST;
			lx.req_wdata <= twi_port_pkg::BYTE_RST;
			lx.req_faddr <= twi_port_pkg::PTR_RST;
		end else if (ce_s) begin
			if (byte_done && st == twi_port_pkg::S_WPTR) begin
				// Pointer byte; fetch ahead for a later read
				ptr          <= rx_byte;
				lx.req_we    <= 1'b0;
				lx.req_faddr <= rx_byte;
				lx.req_tog   <= ~lx.req_tog;
			end else if (byte_done && st == twi_port_pkg::S_WDATA) begin
				// Store at the pointer, then step on
				ptr          <= ptr + twi_port_pkg::PTR_STEP;
				lx.req_we    <= 1'b1;
				lx.req_waddr <= ptr;
				lx.req_wdata <= rx_byte;
				lx.req_faddr <= ptr + twi_port_pkg::PTR_STEP;
				lx.req_tog   <= ~lx.req_tog;
			end else if (load_tx) begin
				// Byte leaves now; fetch the following one
				ptr          <= ptr + twi_port_pkg::PTR_STEP;
				lx.req_we    <= 1'b0;
				lx.req_faddr <= ptr + twi_port_pkg::PTR_STEP;
				lx.req_tog   <= ~lx.req_tog;
			end
		end
	end

	// Reply synchroniser; runs only while the master clocks
	always_ff @(posedge scl or negedge rst_n) begin
		if (!rst_n) begin
			rsp_m <= 1'b0;
			rsp_s <= 1'b0;
		end else begin
			rsp_m <= lx.rsp_tog;
			rsp_s <= rsp_m;
		end
	end

	// Fetched byte kept ready for the next read byte
	always_ff @(posedge scl or negedge rst_n) begin
		if (!rst_n) begin
			rsp_seen <= 1'b0;
			pref     <= twi_port_pkg::BYTE_RST;
		end else if (ce_s && rsp_s != rsp_seen) begin
			rsp_seen <= rsp_s;
			pref     <= lx.rsp_data;
		end
	end

	// Outgoing byte, shifted after each sampled bit
	always_ff @(posedge scl or negedge rst_n) begin
		if (!rst_n) begin
			tx <= twi_port_pkg::BYTE_RST;
		end else if (ce_s) begin
			if (load_tx) begin
				tx <= pref;
			end else if (go && st == twi_port_pkg::S_RD && cnt != twi_port_pkg::ACK_SLOT) begin
				tx <= {tx[6:0], 1'b0};
			end
		end
	end

	// Line drive changes only on the falling clock, so it is
	// steady through every clock-high phase.
	always_ff @(negedge scl or negedge rst_n) begin
		if (!rst_n) begin
			sda_out <= 1'b0;
			sda_oe  <= 1'b0;
		end else if (ce_s) begin
			sda_out <= 1'b0;
			if (ack && cnt == twi_port_pkg::ACK_SLOT) begin
				// Pull low for the whole ninth bit
				sda_oe <= 1'b1;
			end else if (st == twi_port_pkg::S_RD && cnt != twi_port_pkg::ACK_SLOT) begin
				// Open drain: drive only the zeros
				sda_oe <= ~tx[7];
			end else begin
				// Master ack slot, foreign address, idle
				sda_oe <= 1'b0;
			end
		end
	end

	// Core side of the crossing
	core_bridge u_bridge (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.lx       (lx.core),
		.wr_en    (wr_en),
		.wr_addr  (wr_addr),
		.wr_data  (wr_data),
		.rd_en    (rd_en),
		.rd_addr  (rd_addr),
		.rd_data  (rd_data)
	);

	a_ack_held_low: assert property (@(posedge scl) disable iff (!rst_n)
		ce_s && ack && cnt == twi_port_pkg::ACK_SLOT |-> sda_oe && !sda_out)
		else $error("acknowledge not driving data low");

	a_nack_release: assert property (@(posedge scl) disable iff (!rst_n)
		ack_slot && st == twi_port_pkg::S_RD && !ack && sda_in && ce_s ##1 ce_s |-> !sda_oe)
		else $error("data line held after not-acknowledge");

	a_foreign_addr: assert property (@(posedge scl) disable iff (!rst_n)
		byte_done && st == twi_port_pkg::S_ADDR && !addr_hit |=> st == twi_port_pkg::S_IGN && !ack)
		else $error("foreign address not ignored");

	a_start_opens: assert property (@(posedge scl) disable iff (!rst_n)
		ce_s && start_evt |=> st == twi_port_pkg::S_ADDR && cnt == twi_port_pkg::FIRST_BIT)
		else $error("start did not open address byte");

	a_ptr_load: assert property (@(posedge scl) disable iff (!rst_n)
		byte_done && st == twi_port_pkg::S_WPTR |=> ptr == $past(rx_byte) && st == twi_port_pkg::S_WDATA)
		else $error("pointer byte not loaded");

	a_write_step: assert property (@(posedge scl) disable iff (!rst_n)
		byte_done && st == twi_port_pkg::S_WDATA |=> lx.req_we && lx.req_waddr == $past(ptr) &&
		ptr == $past(ptr) + twi_port_pkg::PTR_STEP)
		else $error("write byte not stored at pointer");

	a_read_step: assert property (@(posedge scl) disable iff (!rst_n)
		load_tx |=> tx == $past(pref) && ptr == $past(ptr) + twi_port_pkg::PTR_STEP)
		else $error("read byte not taken or pointer not advanced");

	// Ack must be up in the ninth bit itself and dropped after it
	a_byte_ack: assert property (@(posedge scl) disable iff (!rst_n)
		byte_done && (st == twi_port_pkg::S_WPTR || st == twi_port_pkg::S_WDATA) ##1
		ce_s && !start_evt && !stop_evt |-> ack && ack_slot ##1 !ack)
		else $error("received byte not acknowledged in ninth bit");

	a_read_goes_on: assert property (@(posedge scl) disable iff (!rst_n)
		ack_slot && st == twi_port_pkg::S_RD && !ack && !sda_in |=> st == twi_port_pkg::S_RD)
		else $error("read ended without not-acknowledge");

	// Ignored transfers never touch the data line
	a_ignore_quiet: assert property (@(posedge scl) disable iff (!rst_n)
		st == twi_port_pkg::S_IGN |-> !sda_oe)
		else $error("data line driven while ignoring the bus");

	// A stop with no start behind it parks the sequencer
	a_stop_closes: assert property (@(posedge scl) disable iff (!rst_n)
		ce_s && stop_evt && !start_evt |=> st == twi_port_pkg::S_IDLE && cnt == twi_port_pkg::CNT_RST)
		else $error("stop did not close the transfer");
endmodule // twi_slave_port

`default_nettype wire

// ### hdl/xfer_if.sv
`default_nettype none

// Word crossing between the bus clock and the core clock
interface xfer_if;
	logic       req_tog;   // Flips once per request
	logic       req_we;    // Request carries a write
	logic [7:0] req_waddr; // Write location
	logic [7:0] req_wdata; // Write byte
	logic [7:0] req_faddr; // Location to fetch ahead
	logic       rsp_tog;   // Flips once per fetched byte
	logic [7:0] rsp_data;  // Fetched byte

	modport link (output req_tog, req_we, req_waddr, req_wdata, req_faddr, input rsp_tog, rsp_data);
	modport core (input req_tog, req_we, req_waddr, req_wdata, req_faddr, output rsp_tog, rsp_data);
endinterface

`default_nettype wire
